// ### hw/odmb_decoder.sv
// opcode decode and microbranch code generation for the microsequencer
`timescale 1ns/100ps
//
// Summary of operation
// - six-bit first opcode branch code from instruction, applied only for test 37.
// - selected branch code is merged onto the base microaddress.
// - flag double-operand instructions whose source mode is zero.
// - flag halt and reset as privileged for memory management.
// - discrete halt and wait decodes inhibited while status mode bit set.
// - service requests trace trap when trap bit set and instruction not TRAP_RETURN_NO_RETRACE-type.
// - after trap return without retrace, trace waits one more instruction.
// - service request is OR of bus error, stack overflow, power, trace, bus request, console bus request and ps address reference sources.
// - upper lane access for byte instruction with bus address bit 0 set.
// - test 35 supplies bits 5 and 3..0: odd byte and third branch.
// - test 34 supplies bits 3..0: fourth opcode branch.
// - test 33 supplies bits 3..0: odd byte or fourth branch.
// - test 20 supplies bits 1..0: byte, service or fetch.
// - test 31 supplies bit 0: register rewrite or not, mode zero.
// - test 27 supplies bit 0: overlapped fetch, cleared for service or plain fetch.
// - test 25 supplies bits 1..0: bus request, keep waiting or fetch.
// - test 21 supplies bits 1..0 from instruction bit 3 and byte/source.
// - byte indicator raised whenever a byte instruction is held.
// - carry-out select from opcode and extension inputs only.
// - alu function muxed between microword and opcode, selected by alteration field.
// - test-only instructions use plain read cycles for destination data.
// - overflow and carry inputs take bus bits 1 and 0 on direct loads.
// - branch code modifies base address only while a test is requested.
//
module odmb_decoder
  import odmb_pkg::*;
#(
  parameter int UA_W = UA_WIDTH
)
(
  input  wire logic            clk_sys_i,
  input  wire logic            rst_n_i,
  input  wire logic [15:0]     instruction_reg_i,
  input  wire logic [5:0]      micro_branch_test_i,
  input  wire logic [UA_W-1:0] base_microaddr_i,
  input  wire logic            status_mode_bit_i,
  input  wire logic            status_trap_bit_i,
  input  wire logic            instr_done_i,
  input  wire logic            bus_addr_bit0_i,
  input  wire logic            bus_error_i,
  input  wire logic            stack_overflow_i,
  input  wire logic            power_down_i,
  input  wire logic            bus_req_prio_i,
  input  wire logic            console_bus_req_i,
  input  wire logic            ps_addr_ref_i,
  input  wire logic            overlap_fetch_i,
  input  wire logic [3:0]      microword_alu_field_i,
  input  wire logic [3:0]      data_alteration_field_i,
  input  wire logic            eis_active_i,
  input  wire logic [1:0]      eis_cout_sel_i,
  input  wire logic            status_load_i,
  input  wire logic [15:0]     data_select_bus_i,
  input  wire logic            v_rotshf_i,
  input  wire logic            v_compare1_i,
  input  wire logic            v_compare2_i,
  input  wire logic            alu_carry_i,
  output logic [5:0]           basic_branch_code_o,
  output logic [UA_W-1:0]      next_microaddr_o,
  output logic                 two_operand_src_reg_direct_o,
  output logic                 privileged_op_flag_o,
  output logic                 halt_decode_o,
  output logic                 wait_decode_o,
  output logic                 trace_request_o,
  output logic                 trace_deferred_o,
  output logic                 service_request_o,
  output logic                 upper_lane_byte_access_o,
  output logic                 byte_op_indicator_o,
  output logic                 read_cycle_only_o,
  output logic [1:0]           carry_out_select_o,
  output logic [3:0]           alu_function_select_o,
  output logic                 alu_logic_mode_o,
  output logic                 alu_carry_in_lsb_o,
  output logic                 overflow_flag_input_o,
  output logic                 carry_flag_input_o
);

  typedef struct packed {
    logic trace_defer;
  } odmb_state_t;

  odmb_state_t st_q;
  odmb_state_t st_d;

  logic is_dop, is_sop, is_byte, is_sm0, is_dm0;
  logic is_halt, is_wait, is_reset, is_rtt, is_mov, is_cmp;
  logic is_test, is_add, is_sub, is_bic, is_bis, is_shift;
  logic       odd_byte;
  logic [5:0] i1_code;
  logic [3:0] i3_code;
  logic [3:0] i4_code;
  logic [3:0] ir_alu;
  logic       ir_ctl;

  ////////////////////////////////////////////////////////////////////////
  // instruction classes

  odmb_ir_class u_class (
    .ir_i       (instruction_reg_i),
    .is_dop_o   (is_dop),
    .is_sop_o   (is_sop),
    .is_byte_o  (is_byte),
    .is_sm0_o   (is_sm0),
    .is_dm0_o   (is_dm0),
    .is_halt_o  (is_halt),
    .is_wait_o  (is_wait),
    .is_reset_o (is_reset),
    .is_rtt_o   (is_rtt),
    .is_mov_o   (is_mov),
    .is_cmp_o   (is_cmp),
    .is_test_o  (is_test),
    .is_add_o   (is_add),
    .is_sub_o   (is_sub),
    .is_bic_o   (is_bic),
    .is_bis_o   (is_bis),
    .is_shift_o (is_shift)
  );

  ////////////////////////////////////////////////////////////////////////
  // discrete decodes and status terms

  assign two_operand_src_reg_direct_o = is_dop && is_sm0;
  assign privileged_op_flag_o         = is_halt || is_reset;
  // user mode turns halt and wait into no-ops at the source
  assign halt_decode_o = is_halt && !status_mode_bit_i;
  assign wait_decode_o = is_wait && !status_mode_bit_i;
  // the trap bit loaded by a non-retrace return fires only after the
  // next instruction, because then the held instruction is no longer it
  assign trace_request_o = status_trap_bit_i && !is_rtt;
  assign service_request_o = bus_error_i || stack_overflow_i || power_down_i
                          || trace_request_o || bus_req_prio_i
                          || console_bus_req_i || ps_addr_ref_i;
  assign odd_byte                 = is_byte && bus_addr_bit0_i;
  assign upper_lane_byte_access_o = odd_byte;
  assign byte_op_indicator_o      = is_byte;
  assign read_cycle_only_o        = is_test;
  assign trace_deferred_o         = st_q.trace_defer;

  ////////////////////////////////////////////////////////////////////////
  // opcode branch encodings

  always_comb begin
    i1_code = I1_OTHER;
    if (is_halt) begin
      i1_code = I1_HALT;
    end else if (is_wait) begin
      i1_code = I1_WAIT;
    end else if (is_reset) begin
      i1_code = I1_RESET;
    end else if (is_rtt) begin
      i1_code = I1_RTT;
    end else if (is_dop) begin
      i1_code = {I1_DOP, is_sm0, is_dm0, is_byte, is_mov};
    end else if (is_sop) begin
      i1_code = {I1_SOP, is_dm0, is_shift, is_byte, is_test};
    end
  end

  assign i3_code = {1'b0, is_dop, is_dm0, is_byte};

  always_comb begin
    i4_code = 4'h0;
    if (is_mov) begin
      i4_code = 4'h1;
    end else if (is_test) begin
      i4_code = 4'h2;
    end else if (is_add) begin
      i4_code = 4'h3;
    end else if (is_sub) begin
      i4_code = 4'h4;
    end else if (is_bic) begin
      i4_code = 4'h5;
    end else if (is_bis) begin
      i4_code = 4'h6;
    end else if (is_shift) begin
      i4_code = 4'h7;
    end else if (is_sop) begin
      i4_code = 4'h8;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // branch code multiplexer; unlisted tests contribute nothing here

  always_comb begin
    basic_branch_code_o = 6'h00;
    case (micro_branch_test_i)
      BUT_FIRST_OPCODE_BRANCH: begin
        basic_branch_code_o = i1_code;
      end
      BUT_INSTR3: begin
        basic_branch_code_o = {odd_byte, 1'b0, i3_code};
      end
      BUT_INSTR4: begin
        basic_branch_code_o = {2'b00, i4_code};
      end
      BUT_INSTR4B: begin
        basic_branch_code_o = {2'b00, odd_byte ? B33_ODD : i4_code};
      end
      BUT_FETCH: begin
        if (service_request_o) begin
          basic_branch_code_o = {4'h0, B20_SERV};
        end else if (is_byte && is_dm0) begin
          basic_branch_code_o = {4'h0, B20_BYTE};
        end else begin
          basic_branch_code_o = {4'h0, B20_FETCH};
        end
      end
      BUT_REWR: begin
        basic_branch_code_o = {5'h00, is_dm0 && !is_test && (is_dop || is_sop)};
      end
      BUT_OVLAP: begin
        basic_branch_code_o = {5'h00, !service_request_o && overlap_fetch_i};
      end
      BUT_WAIT: begin
        if (bus_req_prio_i) begin
          basic_branch_code_o = {4'h0, B25_BREQ};
        end else if (!console_bus_req_i) begin
          basic_branch_code_o = {4'h0, B25_WAIT};
        end else begin
          basic_branch_code_o = {4'h0, B25_FETCH};
        end
      end
      BUT_INDEX: begin
        basic_branch_code_o = {4'h0, instruction_reg_i[IR_IDX_BIT],
                               is_byte || is_sm0};
      end
      default: begin
        basic_branch_code_o = 6'h00;
      end
    endcase
  end

  // wired-or style merge onto the base address
  assign next_microaddr_o = base_microaddr_i
                          | {{(UA_W-6){1'b0}}, basic_branch_code_o};

  ////////////////////////////////////////////////////////////////////////
  // alu control and condition-code data

  always_comb begin
    ir_alu = ALU_PASS;
    if (is_sub || is_cmp) begin
      ir_alu = ALU_SUB;
    end else if (is_add) begin
      ir_alu = ALU_ADD;
    end else if (is_test && !is_cmp) begin
      ir_alu = ALU_AND;
    end else if (is_bic) begin
      ir_alu = ALU_ANDN;
    end else if (is_bis) begin
      ir_alu = ALU_OR;
    end
  end

  assign ir_ctl = data_alteration_field_i == DAD_IR;
  assign alu_function_select_o = ir_ctl ? ir_alu : microword_alu_field_i;
  assign alu_logic_mode_o = ir_ctl ? (is_bic || is_bis || (is_test && !is_cmp))
                                   : (data_alteration_field_i == DAD_LOGIC);
  assign alu_carry_in_lsb_o = ir_ctl ? (is_sub || is_cmp)
                                     : (data_alteration_field_i == DAD_CIN);
  // no microword term may reach the carry-out mux select
  assign carry_out_select_o = eis_active_i ? eis_cout_sel_i :
                              is_shift ? COUT_SHIFT :
                              (is_sub || is_cmp) ? COUT_INV : COUT_ALU;

  assign overflow_flag_input_o = status_load_i ? data_select_bus_i[DSB_V_BIT] :
                                 is_shift ? v_rotshf_i :
                                 (is_cmp || is_sub) ? (v_compare1_i || v_compare2_i)
                                                    : 1'b0;
  assign carry_flag_input_o = status_load_i ? data_select_bus_i[DSB_C_BIT]
                                            : alu_carry_i;

  ////////////////////////////////////////////////////////////////////////
  // deferred trace indicator

  always_comb begin
    st_d = st_q;
    if (instr_done_i) begin
      st_d.trace_defer = is_rtt && status_trap_bit_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  AST_NO_TEST: assert property (micro_branch_test_i == BUT_NONE
    |-> next_microaddr_o == base_microaddr_i)
    else $error("address modified with no branch test");
  AST_MERGE: assert property (micro_branch_test_i != BUT_NONE
    |-> (next_microaddr_o[5:0] & basic_branch_code_o) == basic_branch_code_o)
    else $error("branch code not merged onto base address");
  AST_I1_ONLY: assert property (micro_branch_test_i != BUT_FIRST_OPCODE_BRANCH && is_dop
    && micro_branch_test_i < BUT_FETCH |-> basic_branch_code_o == 6'h00)
    else $error("first opcode branch code leaked into other test");
  AST_HALT_INH: assert property (status_mode_bit_i
    |-> !halt_decode_o && !wait_decode_o && (privileged_op_flag_o == (is_halt || is_reset)))
    else $error("halt or wait decoded in user mode");
  AST_TRACE_RTT: assert property (is_rtt |-> !trace_request_o)
    else $error("trace trap not deferred after return");
  AST_DEFER: assert property (instr_done_i && is_rtt && status_trap_bit_i
    |=> trace_deferred_o)
    else $error("deferred trace not recorded");
  AST_SERVICE: assert property (bus_error_i || power_down_i || ps_addr_ref_i
    |-> service_request_o)
    else $error("service not requested");
  AST_UPPER: assert property (upper_lane_byte_access_o
    |-> byte_op_indicator_o && bus_addr_bit0_i)
    else $error("upper lane access without odd byte");
  AST_B35_BIT4: assert property (micro_branch_test_i == BUT_INSTR3
    |-> !basic_branch_code_o[4] && (basic_branch_code_o[5] == odd_byte))
    else $error("bad bits for test 35");
  AST_COUT: assert property (eis_active_i |-> carry_out_select_o == eis_cout_sel_i)
    else $error("carry-out select ignores extension");
  AST_ALU_MUX: assert property (!ir_ctl
    |-> alu_function_select_o == microword_alu_field_i)
    else $error("alu function not from microword");
  AST_LOAD: assert property (status_load_i
    |-> overflow_flag_input_o == data_select_bus_i[1]
        && carry_flag_input_o == data_select_bus_i[0])
    else $error("direct status load bits wrong");

  COV_FIRST_OPCODE_BRANCH: cover property (micro_branch_test_i == BUT_FIRST_OPCODE_BRANCH && is_dop);
  COV_ODD: cover property (micro_branch_test_i == BUT_INSTR4B && odd_byte);
  COV_DEFER: cover property (trace_deferred_o ##1 instr_done_i && trace_request_o);
  COV_SERV: cover property (micro_branch_test_i == BUT_FETCH && service_request_o);

endmodule

// ### hw/odmb_ir_class.sv
// instruction class decode of the instruction register
`timescale 1ns/100ps
module odmb_ir_class
  import odmb_pkg::*;
(
  input  wire logic [15:0] ir_i,
  output logic             is_dop_o,
  output logic             is_sop_o,
  output logic             is_byte_o,
  output logic             is_sm0_o,
  output logic             is_dm0_o,
  output logic             is_halt_o,
  output logic             is_wait_o,
  output logic             is_reset_o,
  output logic             is_rtt_o,
  output logic             is_mov_o,
  output logic             is_cmp_o,
  output logic             is_test_o,
  output logic             is_add_o,
  output logic             is_sub_o,
  output logic             is_bic_o,
  output logic             is_bis_o,
  output logic             is_shift_o
);

  logic [2:0] op3;
  logic [5:0] sop;
  logic       dop_logic;
  logic       sop_grp;

  assign op3       = ir_i[14:12];
  assign sop       = ir_i[11:6];
  assign dop_logic = (op3 >= DOP_MOV) && (op3 <= DOP_BIS);
  assign sop_grp   = (op3 == 3'h0) && (sop >= SOP_FIRST) && (sop <= SOP_LAST);

  assign is_add_o   = ir_i[15:12] == OP4_ADD;
  assign is_sub_o   = ir_i[15:12] == OP4_SUB;
  assign is_dop_o   = dop_logic || is_add_o || is_sub_o;
  assign is_sop_o   = sop_grp;
  // add and subtract share the byte bit position but have no byte form
  assign is_byte_o  = ir_i[IR_BYTE_BIT] && (dop_logic || sop_grp);
  assign is_sm0_o   = ir_i[11:9] == 3'h0;
  assign is_dm0_o   = ir_i[5:3] == 3'h0;
  assign is_halt_o  = ir_i == OP_HALT;
  assign is_wait_o  = ir_i == OP_WAIT;
  assign is_reset_o = ir_i == OP_RESET;
  assign is_rtt_o   = ir_i == OP_RTT;
  assign is_mov_o   = op3 == DOP_MOV;
  assign is_cmp_o   = op3 == DOP_CMP;
  assign is_test_o  = (op3 == DOP_CMP) || (op3 == DOP_BIT) || (sop_grp && sop == SOP_TST);
  assign is_bic_o   = op3 == DOP_BIC;
  assign is_bis_o   = op3 == DOP_BIS;
  assign is_shift_o = sop_grp && (sop >= SOP_SHF);

endmodule

// ### inc/odmb_pkg.sv
// constants for the opcode decode and microbranch block
package odmb_pkg;

  localparam int UA_WIDTH = 9;

  // branch micro test numbers (octal 00, 20, 21, 25, 27, 31, 33, 34, 35, 37)
  localparam logic [5:0] BUT_NONE   = 6'h00;
  localparam logic [5:0] BUT_FETCH  = 6'h10;
  localparam logic [5:0] BUT_INDEX  = 6'h11;
  localparam logic [5:0] BUT_WAIT   = 6'h15;
  localparam logic [5:0] BUT_OVLAP  = 6'h17;
  localparam logic [5:0] BUT_REWR   = 6'h19;
  localparam logic [5:0] BUT_INSTR4B = 6'h1b;
  localparam logic [5:0] BUT_INSTR4 = 6'h1c;
  localparam logic [5:0] BUT_INSTR3 = 6'h1d;
  localparam logic [5:0] BUT_FIRST_OPCODE_BRANCH = 6'h1f;

  // instruction word fields and opcodes
  localparam int IR_BYTE_BIT = 15;
  localparam int IR_IDX_BIT  = 3;
  localparam logic [15:0] OP_HALT  = 16'h0000;
  localparam logic [15:0] OP_WAIT  = 16'h0001;
  localparam logic [15:0] OP_RESET = 16'h0005;
  localparam logic [15:0] OP_RTT   = 16'h0006;
  localparam logic [2:0]  DOP_MOV  = 3'h1;
  localparam logic [2:0]  DOP_CMP  = 3'h2;
  localparam logic [2:0]  DOP_BIT  = 3'h3;
  localparam logic [2:0]  DOP_BIC  = 3'h4;
  localparam logic [2:0]  DOP_BIS  = 3'h5;
  localparam logic [3:0]  OP4_ADD  = 4'h6;
  localparam logic [3:0]  OP4_SUB  = 4'he;
  localparam logic [5:0]  SOP_FIRST = 6'h28;
  localparam logic [5:0]  SOP_TST   = 6'h2f;
  localparam logic [5:0]  SOP_SHF   = 6'h30;
  localparam logic [5:0]  SOP_LAST  = 6'h33;

  // branch codes
  localparam logic [5:0] I1_OTHER = 6'h00;
  localparam logic [5:0] I1_HALT  = 6'h01;
  localparam logic [5:0] I1_WAIT  = 6'h02;
  localparam logic [5:0] I1_RESET = 6'h04;
  localparam logic [5:0] I1_RTT   = 6'h05;
  localparam logic [1:0] I1_SOP   = 2'h1;
  localparam logic [1:0] I1_DOP   = 2'h2;
  localparam int         ODD_POS  = 5;
  localparam logic [3:0] B33_ODD  = 4'hf;
  localparam logic [1:0] B20_FETCH = 2'h0;
  localparam logic [1:0] B20_SERV  = 2'h1;
  localparam logic [1:0] B20_BYTE  = 2'h2;
  localparam logic [1:0] B25_FETCH = 2'h0;
  localparam logic [1:0] B25_BREQ  = 2'h1;
  localparam logic [1:0] B25_WAIT  = 2'h2;

  // alu control
  localparam logic [3:0] DAD_IR    = 4'h1;
  localparam logic [3:0] DAD_CIN   = 4'h2;
  localparam logic [3:0] DAD_LOGIC = 4'h3;
  localparam logic [3:0] ALU_ADD  = 4'h9;
  localparam logic [3:0] ALU_SUB  = 4'h6;
  localparam logic [3:0] ALU_AND  = 4'hb;
  localparam logic [3:0] ALU_ANDN = 4'h2;
  localparam logic [3:0] ALU_OR   = 4'he;
  localparam logic [3:0] ALU_PASS = 4'ha;
  localparam logic [1:0] COUT_ALU   = 2'h0;
  localparam logic [1:0] COUT_SHIFT = 2'h1;
  localparam logic [1:0] COUT_INV   = 2'h2;

  // condition-code load bits of the data select bus
  localparam int DSB_V_BIT = 1;
  localparam int DSB_C_BIT = 0;

endpackage

// ### verif/odmb_decoder_tb.sv
// self-checking bench for the opcode decode and microbranch block
`timescale 1ns/100ps
module odmb_decoder_tb;
  import odmb_pkg::*;
  logic        clk_sys_i, rst_n_i, status_mode_bit_i, status_trap_bit_i, instr_done_i;
  logic        bus_addr_bit0_i, bus_error_i, stack_overflow_i, power_down_i, bus_req_prio_i;
  logic        console_bus_req_i, ps_addr_ref_i, overlap_fetch_i, eis_active_i, status_load_i;
  logic        v_rotshf_i, v_compare1_i, v_compare2_i, alu_carry_i;
  logic [15:0] instruction_reg_i, data_select_bus_i;
  logic [5:0]  micro_branch_test_i, basic_branch_code_o;
  logic [8:0]  base_microaddr_i, next_microaddr_o, upc_q;
  logic [3:0]  microword_alu_field_i, data_alteration_field_i, alu_function_select_o;
  logic [1:0]  eis_cout_sel_i, carry_out_select_o;
  logic        two_operand_src_reg_direct_o, privileged_op_flag_o, halt_decode_o, wait_decode_o;
  logic        trace_request_o, trace_deferred_o, service_request_o, upper_lane_byte_access_o;
  logic        byte_op_indicator_o, read_cycle_only_o, alu_logic_mode_o, alu_carry_in_lsb_o;
  logic        overflow_flag_input_o, carry_flag_input_o;
  int          error_cnt = 0;
  int          n_checks = 0;
  odmb_decoder #(.UA_W(9)) uut (.clk_sys_i, .rst_n_i, .instruction_reg_i, .micro_branch_test_i,
    .base_microaddr_i, .status_mode_bit_i, .status_trap_bit_i, .instr_done_i, .bus_addr_bit0_i,
    .bus_error_i, .stack_overflow_i, .power_down_i, .bus_req_prio_i, .console_bus_req_i,
    .ps_addr_ref_i, .overlap_fetch_i, .microword_alu_field_i, .data_alteration_field_i,
    .eis_active_i, .eis_cout_sel_i, .status_load_i, .data_select_bus_i, .v_rotshf_i,
    .v_compare1_i, .v_compare2_i, .alu_carry_i, .basic_branch_code_o, .next_microaddr_o,
    .two_operand_src_reg_direct_o, .privileged_op_flag_o, .halt_decode_o, .wait_decode_o,
    .trace_request_o, .trace_deferred_o, .service_request_o, .upper_lane_byte_access_o,
    .byte_op_indicator_o, .read_cycle_only_o, .carry_out_select_o, .alu_function_select_o,
    .alu_logic_mode_o, .alu_carry_in_lsb_o, .overflow_flag_input_o, .carry_flag_input_o);
  odmb_useq_model #(.UA_W(9)) model (.clk_sys_i, .rst_n_i,
    .next_microaddr_i(next_microaddr_o), .upc_q_o(upc_q));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic put_ir(input logic [15:0] ir, input logic [5:0] t);
    @(negedge clk_sys_i);
    instruction_reg_i = ir;
    micro_branch_test_i = t;
    #5;
  endtask
  task automatic pulse_done();
    @(negedge clk_sys_i);
    instr_done_i = 1'b1;
    @(negedge clk_sys_i);
    instr_done_i = 1'b0;
    #5;
  endtask
  task final_report();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_branch();
    logic [5:0]  tn [7] = '{BUT_FIRST_OPCODE_BRANCH, BUT_INSTR3, BUT_INSTR4, BUT_INSTR4B, BUT_REWR, BUT_OVLAP,
                           BUT_NONE};
    logic [5:0]  ex [7] = '{6'h2d, 6'h06, 6'h01, 6'h01, 6'h01, 6'h01, 6'h00};
    logic [15:0] di [4] = '{OP_HALT, OP_WAIT, OP_RESET, OP_RTT};
    logic [5:0]  dc [4] = '{I1_HALT, I1_WAIT, I1_RESET, I1_RTT};
    overlap_fetch_i = 1'b1;
    for (int i = 0; i < 7; i++) begin
      put_ir(16'h1000, tn[i]);
      chk("code", ex[i], basic_branch_code_o);
      chk("next", 9'h100 | ex[i], next_microaddr_o);
      @(posedge clk_sys_i);
      #1;
      chk("upc", 9'h100 | ex[i], upc_q);
    end
    for (int i = 0; i < 4; i++) begin
      put_ir(di[i], BUT_FIRST_OPCODE_BRANCH);
      chk("code_discrete", dc[i], basic_branch_code_o);
    end
    put_ir(16'h1000, BUT_NONE);
    chk("two_operand_src_reg_direct", 1'b1, two_operand_src_reg_direct_o);
    put_ir(16'h1200, BUT_NONE);
    chk("dop_sm1", 1'b0, two_operand_src_reg_direct_o);
  endtask
  task automatic t_priv();
    for (int m = 0; m < 2; m++) begin
      status_mode_bit_i = m[0];
      put_ir(OP_HALT, BUT_NONE);
      chk("priv_halt", 1'b1, privileged_op_flag_o);
      chk("halt_dec", !m[0], halt_decode_o);
      put_ir(OP_WAIT, BUT_NONE);
      chk("wait_dec", !m[0], wait_decode_o);
      chk("priv_wait", 1'b0, privileged_op_flag_o);
      put_ir(OP_RESET, BUT_NONE);
      chk("priv_reset", 1'b1, privileged_op_flag_o);
    end
    status_mode_bit_i = 1'b0;
  endtask
  task automatic t_trace();
    status_trap_bit_i = 1'b1;
    put_ir(16'h1000, BUT_FETCH);
    chk("trace", 1'b1, trace_request_o);
    chk("serv_trace", B20_SERV, basic_branch_code_o);
    put_ir(OP_RTT, BUT_NONE);
    chk("trace_rtt", 1'b0, trace_request_o);
    pulse_done();
    chk("deferred", 1'b1, trace_deferred_o);
    put_ir(16'h1000, BUT_NONE);
    chk("trace_after", 1'b1, trace_request_o);
    pulse_done();
    chk("deferred_clr", 1'b0, trace_deferred_o);
    status_trap_bit_i = 1'b0;
  endtask
  task automatic t_service();
    for (int i = 0; i < 6; i++) begin
      {bus_error_i, stack_overflow_i, power_down_i, bus_req_prio_i, console_bus_req_i,
       ps_addr_ref_i} = 6'h01 << i;
      put_ir(16'h1000, BUT_FETCH);
      chk("service", 1'b1, service_request_o);
      chk("b20_serv", B20_SERV, basic_branch_code_o);
    end
    {bus_error_i, stack_overflow_i, power_down_i, bus_req_prio_i, console_bus_req_i,
     ps_addr_ref_i} = 6'h04;
    put_ir(16'h1000, BUT_WAIT);
    chk("b25_breq", B25_BREQ, basic_branch_code_o);
    bus_req_prio_i = 1'b0;
    put_ir(16'h1000, BUT_WAIT);
    chk("b25_wait", B25_WAIT, basic_branch_code_o);
    chk("no_service", 1'b0, service_request_o);
    put_ir(16'h1000, BUT_FETCH);
    chk("b20_fetch", B20_FETCH, basic_branch_code_o);
    console_bus_req_i = 1'b1;
    put_ir(16'h1000, BUT_WAIT);
    chk("b25_fetch", B25_FETCH, basic_branch_code_o);
    put_ir(16'h1000, BUT_OVLAP);
    chk("b27_serv", 1'b0, basic_branch_code_o);
    console_bus_req_i = 1'b0;
  endtask
  task automatic t_byte();
    bus_addr_bit0_i = 1'b1;
    put_ir(16'h9000, BUT_INSTR4B);
    chk("upper_lane", 1'b1, upper_lane_byte_access_o);
    chk("byte_ind", 1'b1, byte_op_indicator_o);
    chk("b33_odd", B33_ODD, basic_branch_code_o);
    put_ir(16'h9000, BUT_INSTR3);
    chk("b35_odd", 6'h27, basic_branch_code_o);
    put_ir(16'h9000, BUT_FETCH);
    chk("b20_byte", B20_BYTE, basic_branch_code_o);
    put_ir(16'h9008, BUT_INDEX);
    chk("b21", 2'h3, basic_branch_code_o);
    bus_addr_bit0_i = 1'b0;
    put_ir(16'h9000, BUT_NONE);
    chk("lower_lane", 1'b0, upper_lane_byte_access_o);
  endtask
  task automatic t_alu();
    put_ir(16'h2000, BUT_NONE);
    chk("rd_only_cmp", 1'b1, read_cycle_only_o);
    chk("cout_cmp", COUT_INV, carry_out_select_o);
    microword_alu_field_i = 4'h5;
    put_ir(16'h1000, BUT_NONE);
    chk("rd_only_mov", 1'b0, read_cycle_only_o);
    chk("cout_mov", COUT_ALU, carry_out_select_o);
    chk("alu_uword", 4'h5, alu_function_select_o);
    data_alteration_field_i = DAD_IR;
    put_ir(16'h6000, BUT_NONE);
    chk("alu_add", ALU_ADD, alu_function_select_o);
    status_load_i = 1'b1;
    data_select_bus_i = 16'h0002;
    #5;
    chk("v_load", 1'b1, overflow_flag_input_o);
    chk("c_load0", 1'b0, carry_flag_input_o);
    data_select_bus_i = 16'h0001;
    #5;
    chk("v_load0", 1'b0, overflow_flag_input_o);
    chk("c_load", 1'b1, carry_flag_input_o);
    status_load_i = 1'b0;
    v_rotshf_i = 1'b1;
    alu_carry_i = 1'b1;
    put_ir(16'h0c00, BUT_NONE);
    chk("v_shift", 1'b1, overflow_flag_input_o);
    chk("c_alu", 1'b1, carry_flag_input_o);
    chk("cout_shift", COUT_SHIFT, carry_out_select_o);
    v_rotshf_i = 1'b0;
    v_compare2_i = 1'b1;
    put_ir(16'h2000, BUT_NONE);
    chk("v_cmp", 1'b1, overflow_flag_input_o);
    chk("alu_cmp", ALU_SUB, alu_function_select_o);
    chk("cin_cmp", 1'b1, alu_carry_in_lsb_o);
    chk("mode_cmp", 1'b0, alu_logic_mode_o);
    eis_active_i = 1'b1;
    eis_cout_sel_i = 2'h3;
    // a shift alone would pick the shifter carry, so the extension must win
    put_ir(16'h0c00, BUT_NONE);
    chk("cout_eis", 2'h3, carry_out_select_o);
    chk("v_shift0", 1'b0, overflow_flag_input_o);
    eis_active_i = 1'b0;
    data_alteration_field_i = DAD_LOGIC;
    put_ir(16'h1000, BUT_NONE);
    chk("mode_uword", 1'b1, alu_logic_mode_o);
    chk("cin_uword0", 1'b0, alu_carry_in_lsb_o);
    data_alteration_field_i = DAD_CIN;
    put_ir(16'h1000, BUT_NONE);
    chk("cin_uword", 1'b1, alu_carry_in_lsb_o);
    chk("mode_uword0", 1'b0, alu_logic_mode_o);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    #(50 * 2000);
    error_cnt++;
    final_report();
  end
  initial begin
    rst_n_i = 1'b0;
    {status_mode_bit_i, status_trap_bit_i, instr_done_i, bus_addr_bit0_i, bus_error_i} = '0;
    {stack_overflow_i, power_down_i, bus_req_prio_i, console_bus_req_i, ps_addr_ref_i} = '0;
    {overlap_fetch_i, eis_active_i, status_load_i, v_rotshf_i, v_compare1_i} = '0;
    {v_compare2_i, alu_carry_i, eis_cout_sel_i} = '0;
    instruction_reg_i = 16'h0000;
    data_select_bus_i = 16'h0000;
    micro_branch_test_i = BUT_NONE;
    base_microaddr_i = 9'h100;
    microword_alu_field_i = 4'h0;
    data_alteration_field_i = 4'h0;
    repeat (5) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    t_branch();
    t_priv();
    t_trace();
    t_service();
    t_byte();
    t_alu();
    final_report();
  end
endmodule

// ### verif/odmb_useq_model.sv
// microsequencer model: registers the next microaddress offered by the decoder
`timescale 1ns/100ps
module odmb_useq_model
  import odmb_pkg::*;
#(
  parameter int UA_W = UA_WIDTH
)
(
  input  wire logic            clk_sys_i,
  input  wire logic            rst_n_i,
  input  wire logic [UA_W-1:0] next_microaddr_i,
  output logic [UA_W-1:0]      upc_q_o
);
  // the branch code has already been merged, so the model just takes the address
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      upc_q_o <= '0;
    end else begin
      upc_q_o <= next_microaddr_i;
    end
  end
endmodule
